// ---- sfm_pkg.sv ----
package sfm_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;           // enable, inter_transfer_delay
	localparam logic [ADDR_W-1:0] OFF_TX_DATA = 8'h04;        // transmit holding word
	localparam logic [ADDR_W-1:0] OFF_RX_HOLDING = 8'h08;     // rx_holding_reg
	localparam logic [ADDR_W-1:0] OFF_SERIAL_STATUS = 8'h0C;  // serial_status_reg
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;     // sticky events, read clears
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;       // same layout as events

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_DLY_LSB = 8;
	localparam int DLY_W = 8;
	localparam int FLAGS_W = 4;
	localparam logic [DLY_W-1:0] DLY_RESET = 8'h00;
	localparam logic [FLAGS_W-1:0] MASK_RESET = 4'h0;

	// ------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCK_HALF_NS = 64;
	// least time, rounded up to whole cycles
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_UNIT_CYC = 32;  // clocks per step of inter_transfer_delay

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic rx_overrun_flag;
		logic transfer_done_flag;
		logic tx_holding_empty;
		logic rx_holding_full;
	} sfm_flags_type;

	typedef struct packed {
		logic [DLY_W-1:0] inter_transfer_delay;
		logic enable;
	} sfm_ctrl_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_GAP = 2'b10
	} sfm_state_type;

endpackage

// ---- sfm_shift_engine.sv ----
`timescale 1ns/1ps
module sfm_shift_engine import sfm_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int HALF_CYC = SCK_HALF_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// word side
	input wire logic start,
	input wire logic [WIDTH-1:0] tx_word,
	output logic busy,
	output logic done,
	output logic [WIDTH-1:0] rx_word,
	// serial pins
	output logic sck,
	output logic mosi,
	output logic cs_n,
	input wire logic miso_sync
);

	logic [15:0] half_cnt;       // clocks within one half period
	logic [7:0] bit_cnt;         // bits already finished
	logic [WIDTH-1:0] shreg;     // outgoing bits high, incoming bits low
	logic half_end;
	logic last_bit;

	assign half_end = (half_cnt == 16'(HALF_CYC - 1));
	assign last_bit = (bit_cnt == 8'(WIDTH - 1));

	// ------------------------------------------------------------
	// shifter: mode 0, msb first
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			done <= 1'b0;
			rx_word <= '0;
			sck <= 1'b0;
			mosi <= 1'b0;
			cs_n <= 1'b1;
			half_cnt <= 16'h0000;
			bit_cnt <= 8'h00;
			shreg <= '0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				// load word and present first bit
				if (start) begin
					busy <= 1'b1;
					shreg <= tx_word;
					mosi <= tx_word[WIDTH-1];
					cs_n <= 1'b0;
					half_cnt <= 16'h0000;
					bit_cnt <= 8'h00;
				end
			end else if (half_end) begin
				half_cnt <= 16'h0000;
				sck <= !sck;
				if (!sck) begin
					// rising edge: sample input while output bit stands
					shreg <= {shreg[WIDTH-2:0], miso_sync};
				end else if (last_bit) begin
					// falling edge after last bit: word complete
					busy <= 1'b0;
					done <= 1'b1;
					cs_n <= 1'b1;
					rx_word <= shreg;
				end else begin
					// falling edge: next outgoing bit
					bit_cnt <= bit_cnt + 8'h01;
					mosi <= shreg[WIDTH-1];
				end
			end else begin
				half_cnt <= half_cnt + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_mosi_high_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		busy && sck && !half_end |=> $stable(mosi))
		else $error("data output moved while clock high");

endmodule

// ---- sfm_status_flags.sv ----
`timescale 1ns/1ps
// What this block does
// - done flag rises after last transfer and delay
// - enabling sets holding-empty and done flags
// - received word moved in sets full
// - reading receive holding register clears full
// - unread word overwritten sets overrun flag
// - new words still load during overrun
// - status register read clears overrun flag
module sfm_status_flags import sfm_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DLY_UNIT = DLY_UNIT_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// serial link
	output logic sck,
	output logic mosi,
	output logic cs_n,
	input wire logic miso,
	// interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic aw_got;                      // write address held
	logic w_got;                       // write data held
	logic [ADDR_W-1:0] w_addr;         // held write address
	logic [31:0] w_data;               // held write data
	logic [3:0] w_strb;                // held byte enables
	logic [31:0] wmerge;               // control word after byte merge
	logic [31:0] ctrl_word;            // control register as a bus word
	logic [31:0] rd_word;              // selected read value
	logic rd_hit;                      // read address is mapped
	logic wr_hit;                      // write address is mapped
	logic wr_fire;                     // write performed this cycle
	logic ar_fire;                     // read taken this cycle
	logic wr_ctrl, wr_tx, wr_mask;     // write decode
	logic rd_rx, rd_stat, rd_irq;      // read decode with side effects
	sfm_ctrl_type ctrl;                // enable and delay
	sfm_flags_type serial_status_reg;  // live flags
	sfm_flags_type irq_events;         // sticky events
	sfm_flags_type irq_mask;           // event gates
	sfm_flags_type evt_set;            // events of this cycle
	logic [WIDTH-1:0] tx_hold;         // transmit holding word
	logic [WIDTH-1:0] rx_holding_reg;  // receive holding word
	logic en_q;                        // enable one cycle ago
	logic enable_rise;                 // interface just enabled
	logic miso_meta, miso_sync;        // input synchroniser
	sfm_state_type state, next_state;  // transfer sequencer
	logic [15:0] gap_cnt;              // inter-transfer delay countdown
	logic pending;                     // word waiting in holding register
	logic start;                       // move holding word into shifter
	logic eng_busy, eng_done;          // shifter status
	logic [WIDTH-1:0] eng_rx;          // word from shifter
	logic finish;                      // last transfer and delay complete
	logic ovr_set;                     // overrun this cycle
	logic [15:0] gap_load;             // delay in clocks

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign awready = !aw_got && !bvalid;
	assign wready = !w_got && !bvalid;
	assign arready = !rvalid;
	assign wr_fire = aw_got && w_got && !bvalid;
	assign ar_fire = arvalid && arready;
	assign wr_ctrl = wr_fire && (w_addr == OFF_CTRL);
	assign wr_tx = wr_fire && (w_addr == OFF_TX_DATA) && w_strb[0];
	assign wr_mask = wr_fire && (w_addr == OFF_IRQ_MASK) && w_strb[0];
	assign wr_hit = (w_addr == OFF_CTRL) || (w_addr == OFF_TX_DATA) || (w_addr == OFF_IRQ_MASK);
	assign rd_rx = ar_fire && (araddr == OFF_RX_HOLDING);
	assign rd_stat = ar_fire && (araddr == OFF_SERIAL_STATUS);
	assign rd_irq = ar_fire && (araddr == OFF_IRQ_STATUS);
	assign ctrl_word = (32'(ctrl.enable) << CTRL_EN_BIT) | (32'(ctrl.inter_transfer_delay) << CTRL_DLY_LSB);
	assign rd_hit = (araddr == OFF_CTRL) || (araddr == OFF_TX_DATA) || (araddr == OFF_RX_HOLDING)
		|| (araddr == OFF_SERIAL_STATUS) || (araddr == OFF_IRQ_STATUS) || (araddr == OFF_IRQ_MASK);

	// byte lanes of the control word
	for (genvar i = 0; i < 4; i++) begin : g_merge
		assign wmerge[8*i +: 8] = w_strb[i] ? w_data[8*i +: 8] : ctrl_word[8*i +: 8];
	end

	// read value select; transmit word reads back
	assign rd_word = (araddr == OFF_CTRL) ? ctrl_word :
		(araddr == OFF_TX_DATA) ? 32'(tx_hold) :
		(araddr == OFF_RX_HOLDING) ? 32'(rx_holding_reg) :
		(araddr == OFF_SERIAL_STATUS) ? 32'(serial_status_reg) :
		(araddr == OFF_IRQ_STATUS) ? 32'(irq_events) :
		(araddr == OFF_IRQ_MASK) ? 32'(irq_mask) : 32'h0000_0000;

	// ------------------------------------------------------------
	// write channel: address and data in either order
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			w_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			// capture address
			if (awvalid && awready) begin
				aw_got <= 1'b1;
				w_addr <= awaddr;
			end
			// capture data
			if (wvalid && wready) begin
				w_got <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			// answer once both are held
			if (wr_fire) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (ar_fire) begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// software registers and input synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= '{inter_transfer_delay: DLY_RESET, enable: 1'b0};
			irq_mask <= MASK_RESET;
			tx_hold <= '0;
			en_q <= 1'b0;
			miso_meta <= 1'b0;
			miso_sync <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl.enable <= wmerge[CTRL_EN_BIT];
				ctrl.inter_transfer_delay <= wmerge[CTRL_DLY_LSB +: DLY_W];
			end
			if (wr_mask) begin
				irq_mask <= w_data[FLAGS_W-1:0];
			end
			if (wr_tx) begin
				tx_hold <= w_data[WIDTH-1:0];
			end
			en_q <= ctrl.enable;
			miso_meta <= miso;
			miso_sync <= miso_meta;
		end
	end

	assign enable_rise = ctrl.enable && !en_q;

	// ------------------------------------------------------------
	// transfer sequencer
	// ------------------------------------------------------------
	// a word written while disabled is dropped on enable, never shifted
	assign pending = ctrl.enable && !enable_rise && !serial_status_reg.tx_holding_empty;
	assign gap_load = 16'(ctrl.inter_transfer_delay) * 16'(DLY_UNIT);

	always_comb begin
		next_state = state;
		start = 1'b0;
		finish = 1'b0;
		case (state)
			ST_IDLE: begin
				// first word waits only for a holding register filled while enabled
				if (pending) begin
					start = 1'b1;
					next_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (eng_done) begin
					if (ctrl.inter_transfer_delay != DLY_RESET) begin
						next_state = ST_GAP;
					end else if (pending) begin
						start = 1'b1;
					end else begin
						finish = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			ST_GAP: begin
				// done only after the delay has run out
				if (gap_cnt == 16'h0000) begin
					if (pending) begin
						start = 1'b1;
						next_state = ST_SHIFT;
					end else begin
						finish = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// state and delay count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			gap_cnt <= 16'h0000;
		end else begin
			state <= next_state;
			if (state == ST_SHIFT && eng_done) begin
				gap_cnt <= gap_load - 16'h0001;
			end else if (gap_cnt != 16'h0000) begin
				gap_cnt <= gap_cnt - 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// flags; hardware set wins over a clear in the same cycle, except a transmit write, which wins over the holding-empty set
	// ------------------------------------------------------------
	assign ovr_set = eng_done && serial_status_reg.rx_holding_full && !rd_rx;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_status_reg <= '0;
			rx_holding_reg <= '0;
		end else begin
			// holding register empty
			if (wr_tx) begin
				serial_status_reg.tx_holding_empty <= 1'b0;
			end else if (start || enable_rise) begin
				serial_status_reg.tx_holding_empty <= 1'b1;
			end
			// end of transfer; clock may be stopped once high
			if (finish || enable_rise) begin
				serial_status_reg.transfer_done_flag <= 1'b1;
			end else if (start) begin
				serial_status_reg.transfer_done_flag <= 1'b0;
			end
			// received word lands even during overrun
			if (eng_done) begin
				rx_holding_reg <= eng_rx;
				serial_status_reg.rx_holding_full <= 1'b1;
			end else if (rd_rx) begin
				serial_status_reg.rx_holding_full <= 1'b0;
			end
			// overrun until status read
			if (ovr_set) begin
				serial_status_reg.rx_overrun_flag <= 1'b1;
			end else if (rd_stat) begin
				serial_status_reg.rx_overrun_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// interrupt events: read of event register clears
	// ------------------------------------------------------------
	assign evt_set = '{rx_overrun_flag: ovr_set, transfer_done_flag: finish,
		tx_holding_empty: start, rx_holding_full: eng_done};
	assign irq = |(irq_events & irq_mask);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_events <= '0;
		end else begin
			irq_events <= (rd_irq ? sfm_flags_type'('0) : irq_events) | evt_set;
		end
	end

	// ------------------------------------------------------------
	// shifter
	// ------------------------------------------------------------
	sfm_shift_engine #(
		.WIDTH(WIDTH),
		.HALF_CYC(SCK_HALF_CYC)
	) u_engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(start),
		.tx_word(tx_hold),
		.busy(eng_busy),
		.done(eng_done),
		.rx_word(eng_rx),
		.sck(sck),
		.mosi(mosi),
		.cs_n(cs_n),
		.miso_sync(miso_sync)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_rx_full_set: assert property (eng_done |=> serial_status_reg.rx_holding_full)
		else $error("full flag not set on received word");
	a_rx_read_clear: assert property (rd_rx && !eng_done |=> !serial_status_reg.rx_holding_full)
		else $error("full flag not cleared by data read");
	a_overrun_set: assert property (eng_done && serial_status_reg.rx_holding_full && !rd_rx
		|=> serial_status_reg.rx_overrun_flag)
		else $error("overrun not flagged");
	a_overrun_load: assert property (eng_done && (serial_status_reg.rx_overrun_flag || ovr_set)
		|=> rx_holding_reg == $past(eng_rx))
		else $error("word not loaded during overrun");
	a_status_clear: assert property (rd_stat && !ovr_set |=> !serial_status_reg.rx_overrun_flag)
		else $error("overrun not cleared by status read");
	a_enable_flags: assert property (enable_rise && !wr_tx
		|=> serial_status_reg.tx_holding_empty && serial_status_reg.transfer_done_flag)
		else $error("flags not set on enable");
	a_tx_write_clear: assert property (wr_tx |=> !serial_status_reg.tx_holding_empty)
		else $error("empty flag not cleared by write");
	a_tx_load_set: assert property (start && !wr_tx ##1 !wr_tx |=> serial_status_reg.tx_holding_empty)
		else $error("empty flag not set on load");
	a_done_after_gap: assert property (state == ST_SHIFT && eng_done && ctrl.inter_transfer_delay != DLY_RESET
		|=> !serial_status_reg.transfer_done_flag [*2])
		else $error("done flag rose before delay");
	a_done_no_gap: assert property (state == ST_SHIFT && eng_done && ctrl.inter_transfer_delay == DLY_RESET
		&& !pending |=> serial_status_reg.transfer_done_flag)
		else $error("done flag late without delay");
	a_idle_no_shift: assert property (state == ST_IDLE |-> !eng_busy)
		else $error("shifter busy while sequencer idle");

	c_overrun: cover property (ovr_set);
	c_gap_done: cover property (state == ST_GAP ##1 finish);
	c_back_to_back: cover property (state == ST_SHIFT && start);
	c_irq: cover property ($rose(irq));

endmodule

// ---- sfm_spi_slave_model.sv ----
`timescale 1ns/1ps
module sfm_slave_model (
	// serial pins from the master
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	// word to answer with, and word seen
	input wire logic [7:0] reply,
	output logic [7:0] captured,
	// serial pin back to the master
	output logic miso
);
	// ------------------------------------------------------------
	// behavioural mode 0 slave
	// ------------------------------------------------------------
	logic [7:0] shift; // outgoing bits, msb first

	initial begin
		miso = 1'b1;
		captured = 8'h00;
		shift = 8'h00;
	end

	// load the answer and present its msb once selected
	always @(negedge cs_n) begin
		shift = reply;
		miso <= reply[7];
	end

	// take the master's bit on the rising edge
	always @(posedge sck) begin
		if (!cs_n) begin
			captured <= {captured[6:0], mosi};
		end
	end

	// next bit after each falling edge
	always @(negedge sck) begin
		if (!cs_n) begin
			shift = {shift[6:0], 1'b0};
			miso <= shift[7];
		end
	end

	// released line: no pull, so show the inverse of the last value
	always @(posedge cs_n) begin
		miso <= ~miso;
	end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench import sfm_pkg::*;;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic aclk, aresetn;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_val;
	logic [1:0] bresp, rresp;
	logic sck, mosi, cs_n, miso, irq;
	logic [7:0] reply, captured;
	int mismatches, checked, n;

	// clock, 4 ns period
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	sfm_status_flags i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.sck(sck), .mosi(mosi), .cs_n(cs_n), .miso(miso), .irq(irq));

	sfm_slave_model i_slave (.sck(sck), .cs_n(cs_n), .mosi(mosi), .reply(reply), .captured(captured),
		.miso(miso));

	// ------------------------------------------------------------
	// reporting
	// ------------------------------------------------------------
	task automatic test_done();
		$display("mismatches %0d, checks %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// a wait that ran out ends the run
	task automatic hang(input string what);
		mismatches++;
		$display("unexpected at %0t: no answer for %s", $time, what);
		test_done();
	endtask

	// ------------------------------------------------------------
	// register bus tasks
	// ------------------------------------------------------------
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		// each half is released at its own taking edge, then the answer
		while (k < 100) begin
			@(posedge aclk);
			k++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				check(32'(bresp), 32'(er), "write response");
				break;
			end
		end
		if (k >= 100) hang("write");
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		int k;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		while (k < 100) begin
			@(posedge aclk);
			k++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				d = rdata;
				check(32'(rresp), 32'(er), "read response");
				break;
			end
		end
		if (k >= 100) hang("read");
	endtask

	// wait for chip select to reach a level
	task automatic wait_cs(input logic lvl);
		int k;
		for (k = 0; k < 1000 && cs_n !== lvl; k++) @(posedge aclk);
		if (k >= 1000) hang("chip select");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		reply = 8'h3C;
		mismatches = 0;
		checked = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// flags clear before enabling
		axi_read(OFF_SERIAL_STATUS, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_0000, "status after reset");
		// enable with one step of gap between words
		axi_write(OFF_CTRL, 32'h0000_0101, RESP_OKAY);
		axi_read(OFF_SERIAL_STATUS, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_0006, "status on enable");
		axi_read(OFF_CTRL, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_0101, "control readback");
		// two words, the second held while the first shifts
		axi_write(OFF_TX_DATA, 32'h0000_00A5, RESP_OKAY);
		axi_write(OFF_TX_DATA, 32'h0000_005A, RESP_OKAY);
		axi_read(OFF_SERIAL_STATUS, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_0000, "status with word held");
		wait_cs(1'b0);
		wait_cs(1'b1);
		check(32'(captured), 32'h0000_00A5, "first word on the line");
		reply <= 8'hC3;
		wait_cs(1'b0);
		wait_cs(1'b1);
		repeat (2) @(posedge aclk);
		// second word lands on an unread one; gap still running
		axi_read(OFF_SERIAL_STATUS, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_000B, "status after overrun");
		axi_read(OFF_RX_HOLDING, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_00C3, "newest word kept");
		check(32'(captured), 32'h0000_005A, "second word on the line");
		// poll until the gap has run out
		for (n = 0; n < 50; n++) begin
			axi_read(OFF_SERIAL_STATUS, RESP_OKAY, rd_val);
			if (rd_val[2] === 1'b1) break;
		end
		check(rd_val, 32'h0000_0006, "status once idle");
		check(32'({cs_n, sck}), 32'h0000_0002, "link idle once done");
		// interrupt: masked, unmasked, cleared by reading events
		check(32'(irq), 32'h0000_0000, "irq while masked");
		axi_write(OFF_IRQ_MASK, 32'h0000_0008, RESP_OKAY);
		check(32'(irq), 32'h0000_0001, "irq on overrun event");
		axi_read(OFF_IRQ_STATUS, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_000F, "event register");
		@(posedge aclk);
		check(32'(irq), 32'h0000_0000, "irq after event read");
		// unmapped places
		axi_read(8'h18, RESP_SLVERR, rd_val);
		check(rd_val, 32'h0000_0000, "unmapped read data");
		axi_write(8'h1C, 32'h0000_00FF, RESP_SLVERR);
		// no gap: done flag follows the word at once
		axi_write(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
		axi_write(OFF_TX_DATA, 32'h0000_0096, RESP_OKAY);
		wait_cs(1'b0);
		wait_cs(1'b1);
		axi_read(OFF_SERIAL_STATUS, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_0007, "status right after word");
		check(32'(captured), 32'h0000_0096, "third word on the line");
		axi_read(OFF_RX_HOLDING, RESP_OKAY, rd_val);
		check(rd_val, 32'h0000_00C3, "third word received");
		test_done();
	end
endmodule
